/* File: verilog/spi_target_unit.sv */
/*
  SPI target port with a buffer RAM, DMA-style byte moves and a
  hardware semaphore shared between software and the serial port.
  Assumes an Avalon-MM master on clk_sys and an external SPI controller
  whose select, clock and data arrive asynchronously on pins.
*/
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module spi_target_unit
  import spi_target_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [spi_target_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [spi_target_pkg::DATA_W-1:0] avs_writedata,
  output logic [spi_target_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic select_low,
  input wire logic sck,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe
);

  // ************************************************************
  // State
  // ************************************************************
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic enable_q;
  logic enable_prev_q;
  logic short_q;
  mode_type mode_q;
  logic [7:0] ignored_fill_q;
  logic [7:0] tx_excess_flag_fill_q;
  logic [RAM_AW-1:0] rx_ptr_q;
  logic [RAM_AW-1:0] tx_ptr_q;
  logic [LIMIT_W-1:0] rx_limit_q;
  logic [LIMIT_W-1:0] tx_limit_q;
  logic [LIMIT_W-1:0] rx_count_done_q;
  logic [LIMIT_W-1:0] tx_count_done_q;
  logic [LIMIT_W-1:0] rx_cnt_q;
  logic [LIMIT_W-1:0] tx_cnt_q;
  logic [7:0] cur_tx_q;
  logic cur_buf_q;
  logic done_ev_q;
  logic rxfull_ev_q;
  logic grant_ev_q;
  logic tx_excess_q;
  logic rx_excess_q;
  logic sel_prev_q;
  owner_type owner_q;
  owner_type owner_d;
  xfer_type xfer_q;
  xfer_type xfer_d;
  logic pend_q;
  logic pend_d;
  logic grant_set;
  logic done_set;
  logic [7:0] ram [0:(1<<RAM_AW)-1];

  link_type link_raw;
  link_type link_s;
  logic eng_miso;
  logic [7:0] eng_rx_byte;
  logic eng_rx_done;

  // ************************************************************
  // Pin synchronisers and bit engine
  // ************************************************************
  assign link_raw = '{select_low: select_low, sck: sck, mosi: mosi};

  sync2 #(
    .W(3),
    .RST(LINK_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(link_raw),
    .sync_out(link_s)
  );

  wire logic frame_active = (xfer_q == XF_GRANTED) | (xfer_q == XF_IGNORED);

  spi_shift_engine u_engine (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .link(link_s),
    .mode(mode_q),
    .active(frame_active),
    .tx_byte(cur_tx_q),
    .miso_q(eng_miso),
    .rx_byte_q(eng_rx_byte),
    .rx_done_q(eng_rx_done)
  );

  assign miso_out = eng_miso;
  assign miso_oe = frame_active & ~link_s.select_low;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire logic acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_q;
  assign avs_readdata = rdata_q;
  wire logic wr_fire = avs_write & ack_q;
  wire logic wd0 = avs_writedata[0];
  wire logic in_ram = avs_address[11:10] == RAM_WINDOW_SEL;
  wire logic [RAM_AW-1:0] ram_word = avs_address[RAM_AW+1:2];
  wire logic sel_claim = avs_address == CLAIM_TASK_OFF;
  wire logic sel_handback = avs_address == HANDBACK_TASK_OFF;
  wire logic sel_done = avs_address == DONE_EVENT_OFF;
  wire logic sel_rxfull = avs_address == RXFULL_EVENT_OFF;
  wire logic sel_grant = avs_address == GRANT_EVENT_OFF;
  wire logic sel_short = avs_address == SHORTCUT_OFF;
  wire logic sel_sem = avs_address == SEM_STATE_OFF;
  wire logic sel_stat = avs_address == XFER_STATUS_OFF;
  wire logic sel_en = avs_address == PORT_ENABLE_OFF;
  wire logic sel_rxp = avs_address == RX_PTR_OFF;
  wire logic sel_rxl = avs_address == RX_LIMIT_OFF;
  wire logic sel_rxc = avs_address == RX_COUNT_OFF;
  wire logic sel_txp = avs_address == TX_PTR_OFF;
  wire logic sel_txl = avs_address == TX_LIMIT_OFF;
  wire logic sel_txc = avs_address == TX_COUNT_OFF;
  wire logic sel_cfg = avs_address == MODE_CFG_OFF;
  wire logic sel_ifill = avs_address == IGNORED_FILL_OFF;
  wire logic sel_ofill = avs_address == TX_EXCESS_FLAG_FILL_OFF;

  wire logic task_claim = wr_fire & sel_claim & avs_writedata[TRIGGER_BIT];
  wire logic task_handback = wr_fire & sel_handback & avs_writedata[TRIGGER_BIT];

  wire logic [DATA_W-1:0] rd_mux =
    in_ram ? 32'(ram[ram_word]) :
    sel_done ? 32'(done_ev_q) :
    sel_rxfull ? 32'(rxfull_ev_q) :
    sel_grant ? 32'(grant_ev_q) :
    sel_short ? 32'(short_q) :
    sel_sem ? 32'(owner_q) :
    sel_stat ? 32'({rx_excess_q, tx_excess_q}) :
    sel_en ? 32'(enable_q) :
    sel_rxp ? 32'(rx_ptr_q) :
    sel_rxl ? 32'(rx_limit_q) :
    sel_rxc ? 32'(rx_count_done_q) :
    sel_txp ? 32'(tx_ptr_q) :
    sel_txl ? 32'(tx_limit_q) :
    sel_txc ? 32'(tx_count_done_q) :
    sel_cfg ? 32'({mode_q.cpol, mode_q.cpha, 1'b0}) :
    sel_ifill ? 32'(ignored_fill_q) :
    sel_ofill ? 32'(tx_excess_flag_fill_q) :
    32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc & ~ack_q;
      if (avs_read & ~ack_q)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Only reset clears these; disabling the port leaves them as they are
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      enable_q <= 1'b0;
      enable_prev_q <= 1'b0;
      short_q <= 1'b0;
      mode_q <= '0;
      ignored_fill_q <= FILL_RST;
      tx_excess_flag_fill_q <= FILL_RST;
      rx_ptr_q <= PTR_RST;
      tx_ptr_q <= PTR_RST;
      rx_limit_q <= LIMIT_RST;
      tx_limit_q <= LIMIT_RST;
    end
    else
    begin
      enable_prev_q <= enable_q;
      if (wr_fire)
      begin
        if (sel_en)
          enable_q <= avs_writedata[ENABLE_BIT];
        if (sel_short)
          short_q <= avs_writedata[SHORT_DONE_CLAIM_BIT];
        if (sel_cfg)
          mode_q <= '{cpol: avs_writedata[CFG_CPOL_BIT], cpha: avs_writedata[CFG_CPHA_BIT]};
        if (sel_ifill)
          ignored_fill_q <= avs_writedata[7:0];
        if (sel_ofill)
          tx_excess_flag_fill_q <= avs_writedata[7:0];
        if (sel_rxp)
          rx_ptr_q <= avs_writedata[RAM_AW-1:0];
        if (sel_txp)
          tx_ptr_q <= avs_writedata[RAM_AW-1:0];
        if (sel_rxl)
          rx_limit_q <= avs_writedata[LIMIT_W-1:0];
        if (sel_txl)
          tx_limit_q <= avs_writedata[LIMIT_W-1:0];
      end
    end
  end

  // ************************************************************
  // Semaphore and frame state
  // ************************************************************
  wire logic enable_rise = enable_q & ~enable_prev_q;
  wire logic sel_fall = sel_prev_q & ~link_s.select_low;
  wire logic sel_rise = ~sel_prev_q & link_s.select_low;

  always_comb
  begin
    owner_d = owner_q;
    xfer_d = xfer_q;
    pend_d = pend_q;
    grant_set = 1'b0;
    done_set = 1'b0;
    if (!enable_q)
    begin
      owner_d = SEM_FREE;
      xfer_d = XF_IDLE;
      pend_d = 1'b0;
    end
    else if (enable_rise)
    begin
      owner_d = SEM_CPU;
    end
    else
    begin
      case (xfer_q)
        XF_IDLE:
        begin
          if (sel_fall)
          begin
            if (owner_q == SEM_FREE && !task_claim)
            begin
              owner_d = SEM_PORT;
              xfer_d = XF_GRANTED;
            end
            else
            begin
              xfer_d = XF_IGNORED;
            end
          end
        end
        XF_GRANTED:
        begin
          if (sel_rise)
            xfer_d = XF_FINISH;
        end
        XF_FINISH:
        begin
          xfer_d = XF_IDLE;
          done_set = 1'b1;
          owner_d = SEM_FREE;
          pend_d = 1'b0;
          if (pend_q | task_claim | short_q)
          begin
            owner_d = SEM_CPU;
            grant_set = 1'b1;
          end
        end
        XF_IGNORED:
        begin
          if (sel_rise)
            xfer_d = XF_IDLE;
        end
        default:
        begin
          xfer_d = XF_IDLE;
        end
      endcase
      if (task_claim && xfer_q != XF_FINISH)
      begin
        if (owner_q == SEM_PORT)
        begin
          pend_d = 1'b1;
        end
        else
        begin
          owner_d = SEM_CPU;
          grant_set = 1'b1;
        end
      end
      if (task_handback && !task_claim && owner_q == SEM_CPU)
        owner_d = SEM_FREE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      owner_q <= SEM_FREE;
      xfer_q <= XF_IDLE;
      pend_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      owner_q <= owner_d;
      xfer_q <= xfer_d;
      pend_q <= pend_d;
      sel_prev_q <= link_s.select_low;
    end
  end

  // ************************************************************
  // Byte moves between engine and buffer RAM
  // ************************************************************
  wire logic starting = (xfer_q == XF_IDLE) & sel_fall;
  wire logic granted_next = xfer_d == XF_GRANTED;
  wire logic byte_in = eng_rx_done & (xfer_q == XF_GRANTED);
  wire logic [LIMIT_W-1:0] tx_next_cnt = starting ? LIMIT_RST : tx_cnt_q + LIMIT_W'(cur_buf_q);
  wire logic next_from_buf = tx_next_cnt < tx_limit_q;
  wire logic [7:0] tx_fetch = ram[tx_ptr_q + tx_next_cnt[RAM_AW-1:0]];
  wire logic [7:0] next_byte = next_from_buf ? tx_fetch : tx_excess_flag_fill_q;
  wire logic rx_room = rx_cnt_q < rx_limit_q;
  wire logic dma_we = byte_in & rx_room;
  wire logic [RAM_AW-1:0] dma_addr = rx_ptr_q + rx_cnt_q[RAM_AW-1:0];
  wire logic rxfull_set = dma_we & (rx_cnt_q + 14'h0001 == rx_limit_q);
  wire logic rx_excess_set = byte_in & ~rx_room;
  wire logic tx_excess_set = byte_in & ~cur_buf_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rx_cnt_q <= LIMIT_RST;
      tx_cnt_q <= LIMIT_RST;
      cur_tx_q <= FILL_RST;
      cur_buf_q <= 1'b0;
      rx_count_done_q <= LIMIT_RST;
      tx_count_done_q <= LIMIT_RST;
    end
    else if (starting)
    begin
      // Same pointers each frame: data resent, buffer overwritten
      rx_cnt_q <= LIMIT_RST;
      tx_cnt_q <= LIMIT_RST;
      cur_tx_q <= granted_next ? next_byte : ignored_fill_q;
      cur_buf_q <= granted_next & next_from_buf;
    end
    else if (byte_in)
    begin
      tx_cnt_q <= tx_next_cnt;
      cur_tx_q <= next_byte;
      cur_buf_q <= next_from_buf;
      if (rx_room)
        rx_cnt_q <= rx_cnt_q + 14'h0001;
    end
    else if (xfer_q == XF_FINISH)
    begin
      rx_count_done_q <= rx_cnt_q;
      tx_count_done_q <= tx_cnt_q;
    end
  end

  // Serial writes win a clash with a bus write to the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (dma_we)
      ram[dma_addr] <= eng_rx_byte;
    else if (wr_fire & in_ram)
      ram[ram_word] <= avs_writedata[7:0];
  end

  // ************************************************************
  // Events and status flags
  // ************************************************************
  // A hardware set in the same cycle as a software clear wins
  wire logic ev_clr = wr_fire & ~wd0;
  wire logic stat_clr_tx = wr_fire & sel_stat & avs_writedata[STAT_TX_EXCESS_BIT];
  wire logic stat_clr_rx = wr_fire & sel_stat & avs_writedata[STAT_RX_EXCESS_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      done_ev_q <= 1'b0;
      rxfull_ev_q <= 1'b0;
      grant_ev_q <= 1'b0;
      tx_excess_q <= 1'b0;
      rx_excess_q <= 1'b0;
    end
    else
    begin
      done_ev_q <= done_set | (done_ev_q & ~(ev_clr & sel_done));
      rxfull_ev_q <= rxfull_set | (rxfull_ev_q & ~(ev_clr & sel_rxfull));
      grant_ev_q <= grant_set | (grant_ev_q & ~(ev_clr & sel_grant));
      tx_excess_q <= tx_excess_set | (tx_excess_q & ~stat_clr_tx);
      rx_excess_q <= rx_excess_set | (rx_excess_q & ~stat_clr_rx);
    end
  end

endmodule : spi_target_unit

/* File: verilog/spi_target_pkg.sv */
/*
  Constants, types and register map of the SPI target port with buffer DMA.
  Assumes a single 20 MHz system clock, a synchronous active-low reset and
  an Avalon-MM master that addresses the registers by byte address.
*/
package spi_target_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int RAM_AW = 8;
  localparam int LIMIT_W = 14;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] CLAIM_TASK_OFF = 12'h024;
  localparam logic [11:0] HANDBACK_TASK_OFF = 12'h028;
  localparam logic [11:0] DONE_EVENT_OFF = 12'h104;
  localparam logic [11:0] RXFULL_EVENT_OFF = 12'h110;
  localparam logic [11:0] GRANT_EVENT_OFF = 12'h128;
  localparam logic [11:0] SHORTCUT_OFF = 12'h200;
  localparam logic [11:0] SEM_STATE_OFF = 12'h400;
  localparam logic [11:0] XFER_STATUS_OFF = 12'h440;
  localparam logic [11:0] PORT_ENABLE_OFF = 12'h500;
  localparam logic [11:0] RX_PTR_OFF = 12'h534;
  localparam logic [11:0] RX_LIMIT_OFF = 12'h538;
  localparam logic [11:0] RX_COUNT_OFF = 12'h53C;
  localparam logic [11:0] TX_PTR_OFF = 12'h544;
  localparam logic [11:0] TX_LIMIT_OFF = 12'h548;
  localparam logic [11:0] TX_COUNT_OFF = 12'h54C;
  localparam logic [11:0] MODE_CFG_OFF = 12'h554;
  localparam logic [11:0] IGNORED_FILL_OFF = 12'h55C;
  localparam logic [11:0] TX_EXCESS_FLAG_FILL_OFF = 12'h5C0;
  // Buffer RAM window: one byte per word at 0x800..0xBFC
  localparam logic [1:0] RAM_WINDOW_SEL = 2'h2;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int TRIGGER_BIT = 0;
  localparam int SHORT_DONE_CLAIM_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam int CFG_CPHA_BIT = 1;
  localparam int CFG_CPOL_BIT = 2;
  localparam int STAT_TX_EXCESS_BIT = 0;
  localparam int STAT_RX_EXCESS_BIT = 1;
  localparam logic [7:0] FILL_RST = 8'h00;
  localparam logic [13:0] LIMIT_RST = 14'h0000;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [2:0] LINK_RST = 3'h4;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    SEM_FREE = 2'b00,
    SEM_CPU = 2'b01,
    SEM_PORT = 2'b11
  } owner_type;

  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_GRANTED = 2'b01,
    XF_FINISH = 2'b11,
    XF_IGNORED = 2'b10
  } xfer_type;

  typedef struct packed {
    logic select_low;
    logic sck;
    logic mosi;
  } link_type;

  typedef struct packed {
    logic cpol;
    logic cpha;
  } mode_type;

endpackage : spi_target_pkg

/* File: verilog/sync2.sv */
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; bundles are not coherent.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_q <= RST;
      sync_out <= RST;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync2

/* File: verilog/spi_shift_engine.sv */
/*
  Bit engine: finds serial clock edges, samples the input line and
  shifts the current transmit byte out, MSB first.
  Assumes synchronised link inputs and a transmit byte that is valid
  when active rises and again within a few cycles of each rx_done.
*/
`timescale 1ns/1ps
module spi_shift_engine
  import spi_target_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire spi_target_pkg::link_type link,
  input wire spi_target_pkg::mode_type mode,
  input wire logic active,
  input wire logic [7:0] tx_byte,
  output logic miso_q,
  output logic [7:0] rx_byte_q,
  output logic rx_done_q
);

  logic sck_prev_q;
  logic active_prev_q;
  logic [2:0] in_cnt_q;
  logic [2:0] out_cnt_q;
  logic [7:0] rx_sh_q;

  wire logic rise = link.sck & ~sck_prev_q;
  wire logic fall = ~link.sck & sck_prev_q;
  wire logic leading = mode.cpol ? fall : rise;
  wire logic trailing = mode.cpol ? rise : fall;
  wire logic sample_edge = mode.cpha ? trailing : leading;
  wire logic shift_edge = mode.cpha ? leading : trailing;
  wire logic start = active & ~active_prev_q;
  wire logic [7:0] rx_next = {rx_sh_q[6:0], link.mosi};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sck_prev_q <= 1'b0;
      active_prev_q <= 1'b0;
      in_cnt_q <= 3'h0;
      out_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_done_q <= 1'b0;
      miso_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= link.sck;
      active_prev_q <= active;
      rx_done_q <= 1'b0;
      if (start)
      begin
        // Phase 0 shows the first bit before the first edge
        in_cnt_q <= 3'h0;
        out_cnt_q <= mode.cpha ? 3'h0 : 3'h1;
        miso_q <= tx_byte[7];
      end
      else if (active)
      begin
        if (sample_edge)
        begin
          rx_sh_q <= rx_next;
          in_cnt_q <= in_cnt_q + 3'h1;
          if (in_cnt_q == 3'h7)
          begin
            rx_byte_q <= rx_next;
            rx_done_q <= 1'b1;
          end
        end
        if (shift_edge)
        begin
          miso_q <= tx_byte[3'h7 - out_cnt_q];
          out_cnt_q <= out_cnt_q + 3'h1;
        end
      end
    end
  end

endmodule : spi_shift_engine

/* File: verification/spi_target_assertions.sv */
/*
  Concurrent checks on the pins and register bus of spi_target_unit.
  Assumes one clk_sys domain with synchronous active-low rst_b.
*/
`timescale 1ns/1ps
module spi_target_assertions
  import spi_target_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [spi_target_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [spi_target_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [spi_target_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic select_low,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire req = avs_read || avs_write;
  chk_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request waited more than one cycle");
  chk_new_wait: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
    else $error("new request skipped its wait state");
  chk_wait_req: assert property (avs_waitrequest |-> req)
    else $error("waitrequest without a request");
  chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_oe_rise: assert property ($rose(miso_oe) |-> !$past(select_low, 2) && !select_low)
    else $error("target-out enabled without select");
  chk_oe_hold: assert property (miso_oe && !select_low |=> miso_oe)
    else $error("target-out dropped within a frame");
  chk_oe_idle: assert property (select_low [*8] |-> !miso_oe)
    else $error("target-out driven while deselected");
  // Six idle clock cycles cover the two-flop sampling and the shift latency
  // The first cycle of a frame loads the first bit, so three enabled cycles are required
  chk_miso_still: assert property ($stable(sck) [*6] ##0 miso_oe && $past(miso_oe) && $past(miso_oe, 2)
    |-> $stable(miso_out))
    else $error("target-out changed without a clock edge");
  cov_frame: cover property ($rose(miso_oe));
  cov_write: cover property (avs_write && !avs_waitrequest);
  cov_end: cover property ($rose(select_low) && miso_oe);
endmodule : spi_target_assertions

/* File: verification/spi_ctrl_model.sv */
/*
  Behavioural SPI controller that drives select, clock and data.
  Assumes target-out resolves to z when released; 400 ns clock period.
*/
`timescale 1ns/1ps
module spi_ctrl_model (
  output logic select_low,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ****
  // Frame engine
  // ****
  initial
  begin
    select_low = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Odd start offset keeps pin edges away from system clock edges
  task automatic frame(input logic cpol, input logic cpha, input int n, input logic [31:0] mo,
                       output logic [31:0] mi);
    int i;
    mi = '0;
    sck = cpol;
    #412 select_low = 1'b0;
    #300;
    for (i = 0; i < 8 * n; i++)
    begin
      if (!cpha) mosi = mo[31-i];
      #200;
      if (!cpha) mi[31-i] = miso;
      sck = !cpol;
      if (cpha) mosi = mo[31-i];
      #200;
      if (cpha) mi[31-i] = miso;
      sck = cpol;
    end
    #300 select_low = 1'b1;
    mosi = !mosi;
  endtask : frame
endmodule : spi_ctrl_model

/* File: verification/tb_top.sv */
/*
  Self-checking bench for spi_target_unit with a controller model.
  Assumes the register map and timing of spi_target_pkg.
*/
`timescale 1ns/1ps
module tb_top;
  import spi_target_pkg::*;
  // ****
  // Stimulus and checks
  // ****
  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_type;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic select_low;
  logic sck;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  wire miso_line = miso_oe ? miso_out : 1'bz;
  int n_mismatch = 0;
  int num_checks = 0;
  row_type rows [0:5] = '{'{SEM_STATE_OFF, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{XFER_STATUS_OFF, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{IGNORED_FILL_OFF, 1'b0, 32'h0000_0000, 32'h0000_0000},
    '{12'h300, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000},
    '{RX_LIMIT_OFF, 1'b1, 32'h0000_FFFF, 32'h0000_3FFF},
    '{TX_LIMIT_OFF, 1'b1, 32'h0000_3FFF, 32'h0000_3FFF}};
  always #25 clk_sys = ~clk_sys;
  spi_target_unit spi_target_unit_inst (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .select_low(select_low), .sck(sck), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe));
  spi_ctrl_model spi_ctrl_model_inst (.select_low(select_low), .sck(sck), .mosi(mosi), .miso(miso_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    chk(avs_readdata, e);
    avs_read <= 1'b0;
  endtask : rd_chk
  task automatic xfer(input logic [1:0] m, input int n, input logic [31:0] mo, input logic claim,
                      input logic [31:0] e);
    logic [31:0] mi;
    bus_wr(MODE_CFG_OFF, {29'h0000_0000, m, 1'b0});
    fork
      spi_ctrl_model_inst.frame(m[1], m[0], n, mo, mi);
      if (claim)
      begin
        repeat (40) @(posedge clk_sys);
        bus_wr(CLAIM_TASK_OFF, 32'h0000_0001);
      end
    join
    repeat (8) @(posedge clk_sys);
    chk(mi, e);
  endtask : xfer
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0000_0000, miso_oe}, 32'h0000_0000);
    foreach (rows[i])
    begin
      if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("table test done");
    bus_wr(RX_LIMIT_OFF, 32'h0000_0002);
    bus_wr(TX_LIMIT_OFF, 32'h0000_0001);
    bus_wr(RX_PTR_OFF, 32'h0000_0020);
    bus_wr(TX_PTR_OFF, 32'h0000_0010);
    bus_wr(TX_EXCESS_FLAG_FILL_OFF, 32'h0000_003C);
    bus_wr(IGNORED_FILL_OFF, 32'h0000_0096);
    bus_wr(12'h840, 32'h0000_00A5);
    bus_wr(12'h888, 32'h0000_0077);
    bus_wr(PORT_ENABLE_OFF, 32'h0000_0001);
    rd_chk(SEM_STATE_OFF, 32'h0000_0001);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0000);
    bus_wr(HANDBACK_TASK_OFF, 32'h0000_0001);
    bus_wr(HANDBACK_TASK_OFF, 32'h0000_0001);
    rd_chk(SEM_STATE_OFF, 32'h0000_0000);
    xfer(2'b00, 3, 32'h1234_5600, 1'b0, 32'hA53C_3C00);
    rd_chk(12'h880, 32'h0000_0012);
    rd_chk(12'h884, 32'h0000_0034);
    rd_chk(12'h888, 32'h0000_0077);
    rd_chk(XFER_STATUS_OFF, 32'h0000_0003);
    rd_chk(TX_COUNT_OFF, 32'h0000_0001);
    rd_chk(RX_COUNT_OFF, 32'h0000_0002);
    rd_chk(DONE_EVENT_OFF, 32'h0000_0001);
    rd_chk(RXFULL_EVENT_OFF, 32'h0000_0001);
    rd_chk(SEM_STATE_OFF, 32'h0000_0000);
    $display("granted frame test done");
    bus_wr(XFER_STATUS_OFF, 32'h0000_0003);
    bus_wr(DONE_EVENT_OFF, 32'h0000_0000);
    xfer(2'b11, 1, 32'h9A00_0000, 1'b0, 32'hA500_0000);
    rd_chk(12'h880, 32'h0000_009A);
    rd_chk(RX_COUNT_OFF, 32'h0000_0001);
    rd_chk(XFER_STATUS_OFF, 32'h0000_0000);
    rd_chk(DONE_EVENT_OFF, 32'h0000_0001);
    $display("repeat frame test done");
    bus_wr(CLAIM_TASK_OFF, 32'h0000_0001);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0001);
    bus_wr(GRANT_EVENT_OFF, 32'h0000_0000);
    bus_wr(CLAIM_TASK_OFF, 32'h0000_0001);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0001);
    bus_wr(DONE_EVENT_OFF, 32'h0000_0000);
    xfer(2'b01, 2, 32'h5555_0000, 1'b0, 32'h9696_0000);
    rd_chk(12'h880, 32'h0000_009A);
    rd_chk(DONE_EVENT_OFF, 32'h0000_0000);
    $display("ignored frame test done");
    bus_wr(GRANT_EVENT_OFF, 32'h0000_0000);
    bus_wr(HANDBACK_TASK_OFF, 32'h0000_0001);
    xfer(2'b10, 1, 32'hC300_0000, 1'b1, 32'hA500_0000);
    rd_chk(SEM_STATE_OFF, 32'h0000_0001);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0001);
    bus_wr(GRANT_EVENT_OFF, 32'h0000_0000);
    bus_wr(SHORTCUT_OFF, 32'h0000_0001);
    bus_wr(HANDBACK_TASK_OFF, 32'h0000_0001);
    xfer(2'b00, 1, 32'h3C00_0000, 1'b1, 32'hA500_0000);
    rd_chk(SEM_STATE_OFF, 32'h0000_0001);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0001);
    bus_wr(GRANT_EVENT_OFF, 32'h0000_0000);
    bus_wr(HANDBACK_TASK_OFF, 32'h0000_0001);
    rd_chk(SEM_STATE_OFF, 32'h0000_0000);
    rd_chk(GRANT_EVENT_OFF, 32'h0000_0000);
    $display("claim test done");
    bus_wr(PORT_ENABLE_OFF, 32'h0000_0000);
    rd_chk(RX_LIMIT_OFF, 32'h0000_0002);
    rd_chk(TX_EXCESS_FLAG_FILL_OFF, 32'h0000_003C);
    bus_wr(PORT_ENABLE_OFF, 32'h0000_0001);
    rd_chk(SEM_STATE_OFF, 32'h0000_0001);
    $display("disable test done");
    tally_and_finish();
  end
endmodule : tb_top
bind spi_target_unit spi_target_assertions chk_inst (.clk_sys(clk_sys), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .select_low(select_low), .sck(sck),
  .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe));
